// File: irs_map.svh
// Register offsets, field positions, reset values and timing counts of the reference selector.
// How it works
// - Seven stored speeds chosen by discrete inputs.
// - Mode 3 selects preset speed after restart.
// - Presets clamp to +-6000 rpm, apply immediately.
// - Presets reset to 100,200,300,-100,-200,-300,500.
// - All three inputs off gives zero reference.
// - Direction off: presets 1 to 3 forward.
// - Direction on: presets 4 to 7 reverse.
// - Thirty-two stored contacts drive internal pulse generator.
// - Mode C selects contact positioning after restart.
// - Contact holds pulses, speed, attribute, ramps, delay.
// - Edge mode starts contact on trigger fall.
// - Level mode: low runs contacts, high jogs.
// - Level mode runs only absolute target contacts.
// - Level mode never auto-loads the next contact.
// - Jog waits for a running contact to finish.
// - Attribute codes: 0 absolute, 1 relative, 2 incremental.
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH
`define IRS_CTRL_OFF     12'h000
`define IRS_STAT_OFF     12'h004
`define IRS_PRESET_OFF   12'h010
`define IRS_CONTACT_OFF  12'h400
`define IRS_CONTACT_MASK 12'hc00
`define IRS_TRIG_BIT     4
`define IRS_RESTART_BIT  8
`define IRS_CTRL_RST     5'h00
`define IRS_MODE_PRESET  4'h3
`define IRS_MODE_CONTACT 4'hc
`define IRS_ATTR_ABSOLUTE 2'h0
`define IRS_ATTR_RELATIVE 2'h1
`define IRS_ATTR_INC     2'h2
`define IRS_SPEED_MAX    16'h1770
`define IRS_SPEED_MIN    16'he890
`define IRS_PRESET1_RST  16'h0064
`define IRS_PRESET2_RST  16'h00c8
`define IRS_PRESET3_RST  16'h012c
`define IRS_PRESET4_RST  16'hff9c
`define IRS_PRESET5_RST  16'hff38
`define IRS_PRESET6_RST  16'hfed4
`define IRS_PRESET7_RST  16'h01f4
`define IRS_NUM_PRESETS  7
`define IRS_NUM_CONTACTS 32
`define IRS_CLK_NS       40
`define IRS_DEB_NS       1000
`define IRS_DEB_CYC      ((`IRS_DEB_NS + `IRS_CLK_NS - 1) / `IRS_CLK_NS)
`endif

// File: irs_pkg.sv
// Types shared by the reference selector.
package irs_pkg;
	typedef enum logic [1:0] {CS_IDLE, CS_RUN, CS_HOLD, CS_JOG} irs_cstate_t;
	typedef logic signed [15:0] irs_speed_t;
endpackage

// File: irs_selector.sv
// Internal reference selector: preset speeds, stored contacts and their APB registers.
`timescale 1ns/10ps
`include "irs_map.svh"
module irs_selector (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        direction_trigger_input_n,
	input  wire logic        speed_select_a_n,
	input  wire logic        speed_select_b_n,
	input  wire logic        contact_trigger_input_n,
	input  wire logic [4:0]  contact_select,
	input  wire logic        contact_done,
	output logic             speed_mode_active,
	output logic             speed_zero_ref,
	output logic             speed_reverse,
	output logic      [15:0] speed_ref,
	output logic             program_contact_positioning,
	output logic             contact_jog_operation,
	output logic             contact_start,
	output logic      [4:0]  contact_index,
	output logic      [31:0] contact_pulses,
	output logic      [15:0] contact_speed,
	output logic      [3:0]  contact_attr,
	output logic      [15:0] contact_accel,
	output logic      [15:0] contact_jerk,
	output logic      [15:0] contact_delay
);

	localparam logic [4:0] DEB_LAST = 5'(`IRS_DEB_CYC - 1);

	// Limits a written speed to the legal signed range.
	function automatic irs_pkg::irs_speed_t clamp_speed(input logic [15:0] v);
		irs_pkg::irs_speed_t s;
		s = irs_pkg::irs_speed_t'(v);
		if (s > irs_pkg::irs_speed_t'(`IRS_SPEED_MAX)) begin
			return irs_pkg::irs_speed_t'(`IRS_SPEED_MAX);
		end
		if (s < irs_pkg::irs_speed_t'(`IRS_SPEED_MIN)) begin
			return irs_pkg::irs_speed_t'(`IRS_SPEED_MIN);
		end
		return s;
	endfunction

	logic                 [4:0]  ctrl_q;
	logic                 [3:0]  act_mode_q;
	logic                        act_trig_q;
	irs_pkg::irs_speed_t         preset_q [`IRS_NUM_PRESETS];
	logic                 [31:0] mem_pulses [`IRS_NUM_CONTACTS];
	logic                 [15:0] mem_speed [`IRS_NUM_CONTACTS];
	logic                 [3:0]  mem_attr [`IRS_NUM_CONTACTS];
	logic                 [15:0] mem_accel [`IRS_NUM_CONTACTS];
	logic                 [15:0] mem_jerk [`IRS_NUM_CONTACTS];
	logic                 [15:0] mem_delay [`IRS_NUM_CONTACTS];
	logic                 [3:0]  sync1_q;
	logic                 [3:0]  sync2_q;
	logic                 [3:0]  deb_q;
	logic                 [4:0]  deb_cnt_q [4];
	logic                        trig_prev_q;
	irs_pkg::irs_cstate_t        cstate_q;
	irs_pkg::irs_cstate_t        cstate_d;
	logic                        rejected_q;
	logic                 [31:0] prdata_q;
	logic                 [31:0] rd_mux;

	// Bus decode.
	wire        acc      = psel & penable;
	wire        wr       = acc & pwrite;
	wire        hit_ctrl = (paddr == `IRS_CTRL_OFF);
	wire        hit_stat = (paddr == `IRS_STAT_OFF);
	wire [11:0] pre_off  = paddr - `IRS_PRESET_OFF;
	wire        hit_pre  = (pre_off[1:0] == 2'h0) && (pre_off[11:2] < 10'h007);
	wire [2:0]  pre_idx  = pre_off[4:2];
	wire        hit_con  = ((paddr & `IRS_CONTACT_MASK) == `IRS_CONTACT_OFF)
	                       && (paddr[4:2] < 3'h6) && (paddr[1:0] == 2'h0);
	wire [4:0]  con_n    = paddr[9:5];
	wire [2:0]  con_f    = paddr[4:2];
	wire        hit_any  = hit_ctrl | hit_stat | hit_pre | hit_con;
	wire        restart  = wr & hit_ctrl & pwdata[`IRS_RESTART_BIT];

	// Every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign pslverr = acc & (~hit_any | (pwrite & hit_stat));
	assign prdata  = prdata_q;

	// Debounced inputs, active high. The trigger history flop resets low, matching the
	// inactive trigger, so no false edge follows reset.
	wire dir_on   = ~deb_q[2];
	wire sela_on  = ~deb_q[1];
	wire selb_on  = ~deb_q[0];
	wire trig_on  = ~deb_q[3];
	wire trig_fall = trig_on & ~trig_prev_q;

	// Modes other than preset speed or stored contacts leave every flag, strobe and speed output idle; the contact fields keep their last launched values.
	wire       mode_spd     = (act_mode_q == `IRS_MODE_PRESET);
	wire       mode_con     = (act_mode_q == `IRS_MODE_CONTACT);
	wire [2:0] spd_idx      = {dir_on, sela_on, selb_on};
	wire       sel_absolute = (mem_attr[contact_select][1:0] == `IRS_ATTR_ABSOLUTE);
	wire       level        = act_trig_q;
	wire       launch       = (cstate_q != irs_pkg::CS_RUN) && (cstate_d == irs_pkg::CS_RUN);
	// A level-mode trigger on a non-absolute contact is refused and flagged.
	wire       refuse       = mode_con & level & (cstate_q == irs_pkg::CS_IDLE) & trig_on
	                          & ~sel_absolute;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = {27'h000_0000, ctrl_q};
		end else if (hit_stat) begin
			rd_mux = {11'h000, contact_index, 5'h00, rejected_q, cstate_q, spd_idx,
			          act_trig_q, act_mode_q};
		end else if (hit_pre) begin
			rd_mux = {{16{preset_q[pre_idx][15]}}, preset_q[pre_idx]};
		end else if (hit_con) begin
			case (con_f)
				3'h0: rd_mux = mem_pulses[con_n];
				3'h1: rd_mux = {16'h0000, mem_speed[con_n]};
				3'h2: rd_mux = {28'h000_0000, mem_attr[con_n]};
				3'h3: rd_mux = {16'h0000, mem_accel[con_n]};
				3'h4: rd_mux = {16'h0000, mem_jerk[con_n]};
				3'h5: rd_mux = {16'h0000, mem_delay[con_n]};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	// Mode and trigger mode become active only through the restart bit.
	// Restart also sends the sequencer back to idle, abandoning a running contact.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= `IRS_CTRL_RST;
			act_mode_q <= 4'h0;
			act_trig_q <= 1'b0;
		end else if (wr & hit_ctrl) begin
			ctrl_q <= pwdata[4:0];
			if (restart) begin
				act_mode_q <= pwdata[3:0];
				act_trig_q <= pwdata[`IRS_TRIG_BIT];
			end
		end
	end

	// Preset speeds take a new value at once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_q[0] <= `IRS_PRESET1_RST;
			preset_q[1] <= `IRS_PRESET2_RST;
			preset_q[2] <= `IRS_PRESET3_RST;
			preset_q[3] <= `IRS_PRESET4_RST;
			preset_q[4] <= `IRS_PRESET5_RST;
			preset_q[5] <= `IRS_PRESET6_RST;
			preset_q[6] <= `IRS_PRESET7_RST;
		end else if (wr & hit_pre) begin
			preset_q[pre_idx] <= clamp_speed(pwdata[15:0]);
		end
	end

	// Contact table, plain memory with no reset.
	// Software must write a contact before it is started, or its fields read unknown.
	always_ff @(posedge pclk) begin
		if (wr & hit_con) begin
			case (con_f)
				3'h0: mem_pulses[con_n] <= pwdata;
				3'h1: mem_speed[con_n] <= pwdata[15:0];
				3'h2: mem_attr[con_n] <= pwdata[3:0];
				3'h3: mem_accel[con_n] <= pwdata[15:0];
				3'h4: mem_jerk[con_n] <= pwdata[15:0];
				3'h5: mem_delay[con_n] <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Two-flop synchroniser, then a stable-for-N-cycles filter per input.
	// A pin that flips back before the filter span ends restarts its count and is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
			deb_q   <= 4'hf;
			for (int i = 0; i < 4; i++) begin
				deb_cnt_q[i] <= 5'h00;
			end
		end else begin
			sync1_q <= {contact_trigger_input_n, direction_trigger_input_n,
			            speed_select_a_n, speed_select_b_n};
			sync2_q <= sync1_q;
			for (int i = 0; i < 4; i++) begin
				if (sync2_q[i] == deb_q[i]) begin
					deb_cnt_q[i] <= 5'h00;
				end else if (deb_cnt_q[i] == DEB_LAST) begin
					deb_q[i]     <= sync2_q[i];
					deb_cnt_q[i] <= 5'h00;
				end else begin
					deb_cnt_q[i] <= deb_cnt_q[i] + 5'h01;
				end
			end
		end
	end

	// Zero-reference flag for the all-inactive input pattern.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_zero_ref <= 1'b0;
		end else begin
			speed_zero_ref <= mode_spd & (spd_idx == 3'h0);
		end
	end

	// Direction flag follows the debounced direction input in preset speed mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_reverse <= 1'b0;
		end else begin
			speed_reverse <= mode_spd & dir_on;
		end
	end

	// Preset speed reference; index 0 is the zero reference.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_ref <= 16'h0000;
		end else if (mode_spd && spd_idx != 3'h0) begin
			speed_ref <= preset_q[spd_idx - 3'h1];
		end else begin
			speed_ref <= 16'h0000;
		end
	end

	assign speed_mode_active           = mode_spd;
	assign program_contact_positioning = mode_con;
	assign contact_jog_operation       = (cstate_q == irs_pkg::CS_JOG);

	// Contact sequencer. In level mode a refused contact, or one that finishes with the trigger low, parks in HOLD,
	// and only a high trigger (jog) followed by a low one selects the next contact, so a
	// trigger raised during a run takes effect once the contact is done.
	always_comb begin
		cstate_d = cstate_q;
		case (cstate_q)
			irs_pkg::CS_IDLE: begin
				if (!level) begin
					if (trig_fall) begin
						cstate_d = irs_pkg::CS_RUN;
					end
				end else if (!trig_on) begin
					cstate_d = irs_pkg::CS_JOG;
				end else if (sel_absolute) begin
					cstate_d = irs_pkg::CS_RUN;
				end else begin
					cstate_d = irs_pkg::CS_HOLD;
				end
			end
			irs_pkg::CS_RUN: begin
				if (contact_done) begin
					if (!level) begin
						cstate_d = irs_pkg::CS_IDLE;
					end else if (trig_on) begin
						cstate_d = irs_pkg::CS_HOLD;
					end else begin
						cstate_d = irs_pkg::CS_JOG;
					end
				end
			end
			irs_pkg::CS_HOLD: begin
				if (!trig_on) begin
					cstate_d = irs_pkg::CS_JOG;
				end
			end
			irs_pkg::CS_JOG: begin
				if (trig_on) begin
					cstate_d = irs_pkg::CS_IDLE;
				end
			end
			default: cstate_d = irs_pkg::CS_IDLE;
		endcase
		if (!mode_con || restart) begin
			cstate_d = irs_pkg::CS_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cstate_q    <= irs_pkg::CS_IDLE;
			trig_prev_q <= 1'b0;
		end else begin
			cstate_q    <= cstate_d;
			trig_prev_q <= trig_on;
		end
	end

	// A refused contact stays flagged until the next contact is launched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rejected_q <= 1'b0;
		end else if (refuse) begin
			rejected_q <= 1'b1;
		end else if (launch) begin
			rejected_q <= 1'b0;
		end
	end

	// The start strobe lasts one cycle per launch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contact_start <= 1'b0;
		end else begin
			contact_start <= launch;
		end
	end

	// Launch hands the selected contact to the pulse generator.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contact_index  <= 5'h00;
			contact_pulses <= 32'h0000_0000;
			contact_speed  <= 16'h0000;
			contact_attr   <= 4'h0;
			contact_accel  <= 16'h0000;
			contact_jerk   <= 16'h0000;
			contact_delay  <= 16'h0000;
		end else if (launch) begin
			contact_index  <= contact_select;
			contact_pulses <= mem_pulses[contact_select];
			contact_speed  <= mem_speed[contact_select];
			contact_attr   <= mem_attr[contact_select];
			contact_accel  <= mem_accel[contact_select];
			contact_jerk   <= mem_jerk[contact_select];
			contact_delay  <= mem_delay[contact_select];
		end
	end

endmodule

// File: irs_chk.sv
// Port checker of the reference selector, bound to the selector.
`timescale 1ns/10ps
module irs_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        direction_trigger_input_n,
	input wire logic        speed_mode_active,
	input wire logic        speed_zero_ref,
	input wire logic        speed_reverse,
	input wire logic [15:0] speed_ref,
	input wire logic        program_contact_positioning,
	input wire logic        contact_jog_operation,
	input wire logic        contact_start
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	start_pulse_a: assert property (contact_start |=> !contact_start)
		else $error("start longer than one cycle");
	mode_excl_a: assert property (!(speed_mode_active && program_contact_positioning))
		else $error("both modes active");
	zero_ref_a: assert property (speed_zero_ref |-> speed_ref == 16'h0000)
		else $error("zero reference not zero");
	idle_ref_a: assert property (!speed_mode_active [*2] |-> speed_ref == 16'h0000)
		else $error("speed outside preset mode");
	jog_mode_a: assert property (contact_jog_operation |->
		program_contact_positioning && !contact_start)
		else $error("jog outside contact mode");
	start_mode_a: assert property (contact_start |-> program_contact_positioning)
		else $error("start outside contact mode");
	rev_dir_a: assert property (speed_reverse |->
		!speed_zero_ref && $past(speed_mode_active))
		else $error("bad reverse");
	deb_rev_a: assert property ($rose(speed_reverse) && $past(speed_mode_active, 2)
		|-> !$past(direction_trigger_input_n, 20))
		else $error("direction taken too early");
	cover property (contact_start);
	cover property (contact_jog_operation);
	cover property (speed_reverse);
endmodule

bind irs_selector irs_chk chk_u (.*);

// File: irs_pgen.sv
// Pulse generator model that ends each started contact after a delay.
`timescale 1ns/10ps
module irs_pgen #(
	parameter int DLY = 6
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic contact_start,
	output logic      contact_done
);
	int cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			contact_done <= 1'b0;
		end else begin
			contact_done <= (cnt == 1);
			if (contact_start) begin
				cnt <= DLY;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// File: internal_reference_selector_tb_top.sv
// Self-checking bench of the reference selector.
`timescale 1ns/10ps
`include "irs_map.svh"
module internal_reference_selector_tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, cpul;
	logic        pready, pslverr, er, gs, spd_on, szero, srev, pos_on, jog, cst, done;
	logic        dir_n = 1'b1, a_n = 1'b1, b_n = 1'b1, trig_n = 1'b1;
	logic [4:0]  csel = 5'h00, cidx;
	logic [15:0] sref, cspd, cacc, cjrk, cdly;
	logic [3:0]  catt;
	logic [15:0] ps [7] = '{`IRS_PRESET1_RST, `IRS_PRESET2_RST, `IRS_PRESET3_RST,
		`IRS_PRESET4_RST, `IRS_PRESET5_RST, `IRS_PRESET6_RST, `IRS_PRESET7_RST};
	int          n_errors = 0, n_tests = 0;
	irs_selector dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .direction_trigger_input_n(dir_n),
		.speed_select_a_n(a_n), .speed_select_b_n(b_n), .contact_trigger_input_n(trig_n),
		.contact_select(csel), .contact_done(done), .speed_mode_active(spd_on),
		.speed_zero_ref(szero), .speed_reverse(srev), .speed_ref(sref),
		.program_contact_positioning(pos_on), .contact_jog_operation(jog),
		.contact_start(cst), .contact_index(cidx), .contact_pulses(cpul),
		.contact_speed(cspd), .contact_attr(catt), .contact_accel(cacc),
		.contact_jerk(cjrk), .contact_delay(cdly));
	irs_pgen #(.DLY(60)) pgen_u (.pclk, .presetn, .contact_start(cst), .contact_done(done));
	always #20 pclk = ~pclk;
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	// Pins are active low; p is {direction, select a, select b} active.
	task automatic drv(input logic t, input logic [2:0] p, input int n);
		@(posedge pclk);
		{trig_n, dir_n, a_n, b_n} <= {t, ~p};
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic wait_start(input int lim);
		gs = 1'b0;
		for (int k = 0; k < lim && !gs; k++) begin
			@(negedge pclk);
			gs = cst === 1'b1;
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 12'h010 + 12'(4 * i), 32'h0);
			chk("preset", rd, 32'(signed'(ps[i])));
		end
		apb(1'b1, 12'h010, 32'h00001b58);
		apb(1'b0, 12'h010, 32'h0);
		chk("clamp hi", rd, 32'h00001770);
		apb(1'b1, 12'h010, 32'hffffe4a8);
		apb(1'b0, 12'h010, 32'h0);
		chk("clamp lo", rd, 32'hffffe890);
		apb(1'b1, 12'h010, 32'h00000064);
		apb(1'b0, 12'h0f0, 32'h0);
		chk("unmapped", 32'(er), 32'h1);
		$display("test registers done");
		apb(1'b1, 12'h000, 32'h003);
		chk("mode early", 32'(spd_on), 32'h0);
		apb(1'b1, 12'h000, 32'h103);
		chk("mode 3", 32'(spd_on), 32'h1);
		for (int p = 0; p < 8; p++) begin
			drv(1'b1, p[2:0], 40);
			chk("ref", {16'h0, sref}, {16'h0, p == 0 ? 16'h0 : ps[p - 1]});
			chk("rev", 32'(srev), 32'(p / 4));
			chk("zero", 32'(szero), 32'(p == 0));
		end
		apb(1'b1, 12'h028, 32'h000004d2);
		repeat (2) @(negedge pclk);
		chk("live", {16'h0, sref}, 32'h04d2);
		drv(1'b1, 3'b011, 5);
		chk("glitch held", 32'(srev), 32'h1);
		drv(1'b1, 3'b111, 40);
		chk("glitch", 32'(srev), 32'h1);
		$display("test preset speeds done");
		drv(1'b1, 3'b000, 40);
		apb(1'b1, 12'h000, 32'h10c);
		chk("mode C", 32'(pos_on), 32'h1);
		apb(1'b1, 12'h4a0, 32'h00012345);
		for (int f = 1; f < 6; f++) begin
			apb(1'b1, 12'h4a0 + 12'(4 * f), (f == 2) ? 32'h0 : 32'(f));
		end
		apb(1'b1, 12'h4c8, 32'h1);
		apb(1'b1, 12'h4e8, 32'h2);
		@(posedge pclk) csel <= 5'd5;
		drv(1'b0, 3'b000, 1);
		wait_start(60);
		chk("edge start", 32'(gs), 32'h1);
		chk("index", 32'(cidx), 32'h5);
		chk("pulses", cpul, 32'h00012345);
		chk("speed", {16'h0, cspd}, 32'h1);
		chk("attr", {28'h0, catt}, 32'h0);
		chk("accel", {16'h0, cacc}, 32'h3);
		chk("jerk", {16'h0, cjrk}, 32'h4);
		chk("delay", {16'h0, cdly}, 32'h5);
		wait_start(120);
		chk("no edge", 32'(gs), 32'h0);
		apb(1'b1, 12'h000, 32'h01c);
		apb(1'b0, 12'h004, 32'h0);
		chk("trig mode held", 32'(rd[4]), 32'h0);
		drv(1'b1, 3'b000, 40);
		apb(1'b1, 12'h000, 32'h11c);
		repeat (2) @(negedge pclk);
		chk("jog", 32'(jog), 32'h1);
		for (int n = 6; n < 8; n++) begin
			@(posedge pclk) csel <= 5'(n);
			drv(1'b0, 3'b000, 40);
			wait_start(30);
			chk("refused", 32'(gs), 32'h0);
			apb(1'b0, 12'h004, 32'h0);
			chk("rejected", 32'(rd[10]), 32'h1);
			drv(1'b1, 3'b000, 40);
		end
		@(posedge pclk) csel <= 5'd5;
		drv(1'b0, 3'b000, 1);
		wait_start(60);
		chk("level start", 32'(gs), 32'h1);
		wait_start(120);
		chk("no auto next", 32'(gs), 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk("hold", 32'(rd[9:8]), 32'h2);
		drv(1'b1, 3'b000, 40);
		drv(1'b0, 3'b000, 1);
		wait_start(60);
		drv(1'b1, 3'b000, 40);
		chk("jog wait", 32'(jog), 32'h0);
		repeat (30) @(negedge pclk);
		chk("jog after", 32'(jog), 32'h1);
		$display("test contacts done");
		stop_test();
	end
endmodule
